// [spi_bridge_defines.svh]
// Timing and field constants for the serial register bridge
`ifndef SPI_BRIDGE_DEFINES_SVH
`define SPI_BRIDGE_DEFINES_SVH
`define CMD_ACCESS_BIT 7
`define CMD_READ_VALUE 1'b1
`define FILLER_ADDR 7'h3F
`define AUX_RST_BIT 1
`define AUX_PHASE_HI 4
`define AUX_PHASE_LO 2
`define BITS_PER_BYTE 4'h8
`define STROBE_PHASE 3'h0
`endif

// [spi_bridge_pkg.sv]
// Types shared by the serial register bridge
package spi_bridge_pkg;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic freeze;
	} core_req_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_CMD = 5'b00010,
		ST_WADDR = 5'b00100,
		ST_WDATA = 5'b01000,
		ST_FAULT = 5'b10000
	} bridge_state_t;
endpackage : spi_bridge_pkg

// [spi_shifter.sv]
// Byte-wide serial shifter driven by clock edges decoded in the top level
`timescale 1ns/1ns
`include "spi_bridge_defines.svh"
module spi_shifter
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk_rise,
	input wire logic sclk_fall,
	input wire logic active,
	input wire logic mosi_bit,
	input wire logic load,
	input wire logic [7:0] load_byte,
	output logic miso_bit,
	output logic [7:0] rx_byte,
	output logic rx_done,
	output logic [3:0] bit_cnt
);
	logic [7:0] rx_reg;
	logic [7:0] tx_reg;
	logic [3:0] cnt_reg;
	logic done_reg;
	wire last_bit = (cnt_reg == (`BITS_PER_BYTE - 4'h1));
	wire [7:0] rx_next = {rx_reg[6:0], mosi_bit};

	// Sample on falling edge, shift out on rising edge, MSB first
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_reg <= 8'h00;
			tx_reg <= 8'h00;
			cnt_reg <= 4'h0;
			done_reg <= 1'b0;
		end
		else if (!active)
		begin
			cnt_reg <= 4'h0;
			done_reg <= 1'b0;
			if (load)
				tx_reg <= load_byte;
		end
		else
		begin
			done_reg <= 1'b0;
			if (load)
				tx_reg <= load_byte;
			else if (sclk_rise && cnt_reg != 4'h0)
				tx_reg <= {tx_reg[6:0], 1'b1};
			if (sclk_fall)
			begin
				rx_reg <= rx_next;
				cnt_reg <= last_bit ? 4'h0 : cnt_reg + 4'h1;
				done_reg <= last_bit;
			end
		end
	end
	assign miso_bit = tx_reg[7];
	assign rx_byte = rx_reg;
	assign rx_done = done_reg;
	assign bit_cnt = cnt_reg;
endmodule : spi_shifter

// [spi_register_bridge.sv]
// Serial-to-core register bridge, top level
// Notes on behaviour
// - Sample input on falling serial clock, change output on rising edge.
// - Serial clock idles low between transfers.
// - All bytes travel most significant bit first.
// - A transaction lasts while select is held high.
// - Dropping and raising select restarts the transaction state.
// - Each transaction starts by sending status high byte then low byte.
// - Access bit one means register read.
// - Access bit zero means register write.
// - Addresses span 00h to 7Fh.
// - Read of 3Fh has no core side effect; filler only.
// - Successive reads of any addresses other than 3Fh return each register in turn.
// - Multi-write takes start address, then increments per data byte.
// - Status is sent once, at the start of a combined sequence.
// - Core side gets address, write data, read/write strobes, freeze.
// - Timing phase from aux bits 4:2, reset from aux bit 1.
// - Freeze high holds core multi-byte registers until it drops.
// - On protocol fault, output is held high until select drops.
`timescale 1ns/1ns
`include "spi_bridge_defines.svh"
module spi_register_bridge
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [4:0] CORE_AUX_OUTPUTS,
	input wire logic SPI_CLK,
	input wire logic SPI_MOSI,
	input wire logic SPI_SEL,
	output logic SPI_MISO,
	input wire logic [15:0] ONLINE_STATUS,
	input wire logic [7:0] CORE_READ_BUS,
	output logic [6:0] CORE_ADDR,
	output logic [7:0] CORE_WRITE_BUS,
	output logic CORE_RD,
	output logic CORE_WR,
	output logic CORE_FREEZE
);
	// ************************************************************
	// Input synchronisation
	// ************************************************************
	logic [1:0] sclk_sync_reg;
	logic [1:0] sel_sync_reg;
	logic [1:0] mosi_sync_reg;
	logic sclk_d_reg;
	logic sel_d_reg;
	spi_bridge_pkg::bridge_state_t state_reg;
	spi_bridge_pkg::bridge_state_t state_next;
	spi_bridge_pkg::core_req_t req_reg;
	spi_bridge_pkg::core_req_t req_next;
	logic [7:0] rx_latch_reg;
	logic [7:0] rdata_reg;
	logic rd_pend_reg;
	logic wr_pend_reg;
	logic [1:0] status_slot_reg;
	logic [7:0] tx_load;
	logic tx_load_en;
	logic shift_miso;
	logic [7:0] rx_byte;
	logic rx_done;
	logic [3:0] bit_cnt;
	logic rst_core_n;

	// Core reset taken from aux bit 1 (active high) combined with port reset
	assign rst_core_n = RST_N & ~CORE_AUX_OUTPUTS[`AUX_RST_BIT];
	wire [2:0] phase = CORE_AUX_OUTPUTS[`AUX_PHASE_HI:`AUX_PHASE_LO];

	// Two-flop synchronisers on all serial input pins
	always_ff @(posedge CLK or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			sclk_sync_reg <= 2'b00;
			sel_sync_reg <= 2'b00;
			mosi_sync_reg <= 2'b00;
			sclk_d_reg <= 1'b0;
			sel_d_reg <= 1'b0;
		end
		else
		begin
			sclk_sync_reg <= {sclk_sync_reg[0], SPI_CLK};
			sel_sync_reg <= {sel_sync_reg[0], SPI_SEL};
			mosi_sync_reg <= {mosi_sync_reg[0], SPI_MOSI};
			sclk_d_reg <= sclk_sync_reg[1];
			sel_d_reg <= sel_sync_reg[1];
		end
	end

	// ************************************************************
	// Edge and framing decode
	// ************************************************************
	wire sel = sel_sync_reg[1];
	wire sclk_rise = sclk_sync_reg[1] & ~sclk_d_reg;
	wire sclk_fall = ~sclk_sync_reg[1] & sclk_d_reg;
	wire sel_start = sel & ~sel_d_reg;
	wire sel_end = ~sel & sel_d_reg;
	wire cmd_is_read = rx_latch_reg[`CMD_ACCESS_BIT] == `CMD_READ_VALUE;
	wire [6:0] cmd_addr = rx_latch_reg[6:0];
	wire is_filler = cmd_addr == `FILLER_ADDR;
	wire phase_ok = phase == `STROBE_PHASE;
	logic byte_evt_reg;
	// Data byte of a write, first or following
	wire data_byte = byte_evt_reg && (state_reg == spi_bridge_pkg::ST_WADDR
		|| state_reg == spi_bridge_pkg::ST_WDATA);

	// Byte shifter, capturing the synchronised input bit
	spi_shifter u_shift
	(
		.clk(CLK),
		.rst_n(rst_core_n),
		.sclk_rise(sclk_rise),
		.sclk_fall(sclk_fall),
		.active(sel),
		.mosi_bit(mosi_sync_reg[1]),
		.load(tx_load_en),
		.load_byte(tx_load),
		.miso_bit(shift_miso),
		.rx_byte(rx_byte),
		.rx_done(rx_done),
		.bit_cnt(bit_cnt)
	);

	// Complete byte held for decoding, flagged one cycle after done
	always_ff @(posedge CLK or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			rx_latch_reg <= 8'h00;
			byte_evt_reg <= 1'b0;
		end
		else
		begin
			byte_evt_reg <= rx_done;
			if (rx_done)
				rx_latch_reg <= rx_byte;
		end
	end

	// ************************************************************
	// Transaction state machine
	// ************************************************************
	always_comb
	begin
		state_next = state_reg;
		if (!sel)
			state_next = spi_bridge_pkg::ST_IDLE;
		else if (sel_start)
			state_next = spi_bridge_pkg::ST_CMD;
		else if (byte_evt_reg)
		begin
			case (state_reg)
				spi_bridge_pkg::ST_CMD:
					state_next = cmd_is_read ? spi_bridge_pkg::ST_CMD
						: spi_bridge_pkg::ST_WADDR;
				spi_bridge_pkg::ST_WADDR:
					state_next = spi_bridge_pkg::ST_WDATA;
				spi_bridge_pkg::ST_WDATA:
					state_next = spi_bridge_pkg::ST_WDATA;
				spi_bridge_pkg::ST_FAULT:
					state_next = spi_bridge_pkg::ST_FAULT;
				default:
					state_next = spi_bridge_pkg::ST_IDLE;
			endcase
		end
		// Short final byte returns to idle; a falling clock edge while idle with select high flags a fault
		if (sel_end && (bit_cnt != 4'h0 || state_reg == spi_bridge_pkg::ST_WADDR))
			state_next = spi_bridge_pkg::ST_IDLE;
		else if (sel && state_reg == spi_bridge_pkg::ST_IDLE && sclk_fall && !sel_start)
			state_next = spi_bridge_pkg::ST_FAULT;
	end

	// ************************************************************
	// Core request generation
	// ************************************************************
	always_comb
	begin
		req_next = req_reg;
		req_next.rd = 1'b0;
		req_next.wr = 1'b0;
		req_next.freeze = sel;
		if (rd_pend_reg && phase_ok)
			req_next.rd = 1'b1;
		if (wr_pend_reg && phase_ok)
			req_next.wr = 1'b1;
		// Address steps on after each write strobe
		if (req_reg.wr)
			req_next.addr = req_reg.addr + 7'h01;
		if (byte_evt_reg && state_reg == spi_bridge_pkg::ST_CMD)
			req_next.addr = cmd_addr;
		if (data_byte)
			req_next.wdata = rx_latch_reg;
	end

	always_ff @(posedge CLK or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			state_reg <= spi_bridge_pkg::ST_IDLE;
			req_reg <= '0;
			rd_pend_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			req_reg <= req_next;
			if (req_reg.rd)
				rdata_reg <= CORE_READ_BUS;
			if (byte_evt_reg && state_reg == spi_bridge_pkg::ST_CMD && cmd_is_read
				&& !is_filler)
				rd_pend_reg <= 1'b1;
			else if (req_next.rd)
				rd_pend_reg <= 1'b0;
			if (data_byte)
				wr_pend_reg <= 1'b1;
			else if (req_next.wr)
				wr_pend_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Output byte sequencing
	// ************************************************************
	// Status high, status low, then read data slots
	always_ff @(posedge CLK or negedge rst_core_n)
	begin
		if (!rst_core_n)
			status_slot_reg <= 2'b00;
		else if (sel_start || !sel)
			status_slot_reg <= 2'b00;
		else if (byte_evt_reg && status_slot_reg != 2'b10)
			status_slot_reg <= status_slot_reg + 2'b01;
	end

	assign tx_load_en = (!sel) || byte_evt_reg;
	// Each load picks the next slot: high byte while idle, then low byte, then read data
	assign tx_load = (!sel) ? ONLINE_STATUS[15:8]
		: (status_slot_reg == 2'b00) ? ONLINE_STATUS[7:0]
		: rdata_reg;

	assign SPI_MISO = (state_reg == spi_bridge_pkg::ST_FAULT) ? 1'b1 : shift_miso;
	assign CORE_ADDR = req_reg.addr;
	assign CORE_WRITE_BUS = req_reg.wdata;
	assign CORE_RD = req_reg.rd;
	assign CORE_WR = req_reg.wr;
	assign CORE_FREEZE = req_reg.freeze;
endmodule : spi_register_bridge

// [spi_register_bridge_props.sv]
// Port-level assertions for the serial register bridge
`timescale 1ns/1ns
module spi_register_bridge_props
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [4:0] CORE_AUX_OUTPUTS,
	input wire logic SPI_CLK,
	input wire logic SPI_SEL,
	input wire logic SPI_MISO,
	input wire logic [6:0] CORE_ADDR,
	input wire logic CORE_RD,
	input wire logic CORE_WR,
	input wire logic CORE_FREEZE
);
	logic run;
	logic have_wr_reg;
	logic [6:0] last_wr_reg;
	// ***********************
	// Tracking and assertions
	// ***********************
	// Either reset source clears the bridge
	assign run = RST_N && !CORE_AUX_OUTPUTS[1];
	// Marks a write already done in this frame
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			have_wr_reg <= 1'b0;
		else
			have_wr_reg <= run && SPI_SEL && (have_wr_reg || CORE_WR);
	end
	// Address of the last write
	always_ff @(posedge CLK)
		last_wr_reg <= CORE_WR ? CORE_ADDR : last_wr_reg;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!run);
	// Strobe spacing, framing and filler
	AST_RD_GAP: assert property (CORE_RD |=> !CORE_RD [*7])
		else $error("read strobes too close");
	AST_WR_GAP: assert property (CORE_WR |=> !CORE_WR [*7])
		else $error("write strobes too close");
	AST_STROBE_IN_FRAME: assert property ((CORE_RD || CORE_WR) |-> CORE_FREEZE)
		else $error("strobe outside a transaction");
	AST_FILLER_QUIET: assert property (CORE_RD |-> CORE_ADDR != 7'h3F)
		else $error("filler read reached the core");
	AST_AUTO_INC: assert property (CORE_WR && have_wr_reg
		|-> CORE_ADDR == last_wr_reg + 7'h01) else $error("write address not incremented");
	// Freeze follows select, output settled at capture
	AST_FREEZE_ON: assert property ($rose(SPI_SEL) |-> ##[1:5] CORE_FREEZE)
		else $error("freeze not raised");
	AST_FREEZE_OFF: assert property ($fell(SPI_SEL) |-> ##[1:5] !CORE_FREEZE)
		else $error("freeze not dropped");
	AST_MISO_SETTLED: assert property ($fell(SPI_CLK)
		|-> $stable(SPI_MISO) && SPI_MISO == $past(SPI_MISO, 3)) else $error("output moved");
	AST_AUX_CLEARS: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(CORE_AUX_OUTPUTS[1]) |=> !CORE_RD && !CORE_WR && CORE_ADDR == 7'h00 && !SPI_MISO)
		else $error("core reset did not clear");
endmodule : spi_register_bridge_props
bind spi_register_bridge spi_register_bridge_props chk (.CLK(CLK), .RST_N(RST_N),
	.CORE_AUX_OUTPUTS(CORE_AUX_OUTPUTS), .SPI_CLK(SPI_CLK), .SPI_SEL(SPI_SEL),
	.SPI_MISO(SPI_MISO), .CORE_ADDR(CORE_ADDR), .CORE_RD(CORE_RD), .CORE_WR(CORE_WR),
	.CORE_FREEZE(CORE_FREEZE));

// [spi_host_model.sv]
// Serial host model: polarity 0, phase 1 master
`timescale 1ns/1ns
module spi_host_model
(
	input wire logic clk,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic sel
);
	// *************
	// Frame control
	// *************
	// Idle: clock low, no select
	initial
	begin
		sclk = 1'b0;
		mosi = 1'b0;
		sel = 1'b0;
	end
	// Raise select with setup before the first clock
	task open_frame;
		sel = 1'b1;
		repeat (4) @(negedge clk);
	endtask : open_frame
	// Launch on rise, capture on fall, MSB first, 160 ns per bit
	task shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			sclk = 1'b1;
			mosi = tx[i];
			repeat (8) @(negedge clk);
			sclk = 1'b0;
			rx[i] = miso;
			repeat (8) @(negedge clk);
		end
	endtask : shift
	// Hold, drop select, leave the data line off its last value
	task close_frame;
		repeat (28) @(negedge clk);
		sel = 1'b0;
		mosi = ~mosi;
		repeat (12) @(negedge clk);
	endtask : close_frame
endmodule : spi_host_model

// [test_spi_register_bridge.sv]
// Self-checking bench for the serial register bridge
`timescale 1ns/1ns
module test_spi_register_bridge;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] aux = 5'h00;
	logic [15:0] status = 16'hA53C;
	logic [7:0] mem [0:127];
	logic [7:0] got [0:7];
	logic [7:0] rdata, wbus;
	logic [6:0] addr;
	logic sclk, mosi, sel, miso, rd, wr, frz;
	int miscompares = 0;
	int tests_run = 0;
	int rds = 0;
	int wrs = 0;
	// ***************
	// Clock and core
	// ***************
	// Clock and free-running timing phase
	always #5 clk = ~clk;
	always @(negedge clk) aux[4:2] <= aux[4:2] + 3'h1;
	// Core register block, strobes counted mid-cycle
	assign rdata = mem[addr];
	always @(negedge clk)
	begin
		if (rd)
			rds++;
		if (wr)
		begin
			mem[addr] = wbus;
			wrs++;
		end
	end
	spi_register_bridge uut (.CLK(clk), .RST_N(rst_n), .CORE_AUX_OUTPUTS(aux), .SPI_CLK(sclk),
		.SPI_MOSI(mosi), .SPI_SEL(sel), .SPI_MISO(miso), .ONLINE_STATUS(status),
		.CORE_READ_BUS(rdata), .CORE_ADDR(addr), .CORE_WRITE_BUS(wbus), .CORE_RD(rd),
		.CORE_WR(wr), .CORE_FREEZE(frz));
	spi_host_model host (.clk(clk), .miso(miso), .sclk(sclk), .mosi(mosi), .sel(sel));
	// ***************
	// Scenarios
	// ***************
	task check8(input string what, input logic [7:0] exp, input logic [7:0] act);
		tests_run++;
		if (act !== exp)
		begin
			miscompares++;
			$display("wrong value %s: expected %h, seen %h", what, exp, act);
		end
	endtask : check8
	// One whole frame, status bytes judged
	task frame(input logic [7:0] q [$]);
		rds = 0;
		wrs = 0;
		host.open_frame();
		for (int k = 0; k < q.size(); k++)
			host.shift(q[k], 8, got[k]);
		host.close_frame();
		check8("status high", status[15:8], got[0]);
		check8("status low", status[7:0], got[1]);
	endtask : frame
	task single_read;
		frame('{8'hA5, 8'hBF, 8'hBF});
		check8("read data", mem[7'h25], got[2]);
		check8("read strobes", 8'h01, 8'(rds));
	endtask : single_read
	task multi_read;
		frame('{8'hFF, 8'h80, 8'hBE, 8'hBF, 8'hBF});
		check8("read 7f", mem[7'h7F], got[2]);
		check8("read 00", mem[7'h00], got[3]);
		check8("read 3e", mem[7'h3E], got[4]);
		check8("read strobes", 8'h03, 8'(rds));
	endtask : multi_read
	task multi_write;
		frame('{8'h7D, 8'h11, 8'h22, 8'h33});
		check8("write 7d", 8'h11, mem[7'h7D]);
		check8("write 7e", 8'h22, mem[7'h7E]);
		check8("write 7f", 8'h33, mem[7'h7F]);
		check8("write strobes", 8'h03, 8'(wrs));
	endtask : multi_write
	task read_write;
		frame('{8'hFE, 8'h20, 8'h99});
		check8("combined read", 8'h22, got[2]);
		check8("combined write", 8'h99, mem[7'h20]);
		check8("combined strobes", 8'h01, 8'(wrs));
		check8("combined reads", 8'h01, 8'(rds));
	endtask : read_write
	// Cut frame, core reset, then a clean frame with new status
	task restart;
		logic [7:0] junk;
		status = 16'h5AC3;
		host.open_frame();
		check8("freeze in frame", 8'h01, {7'h00, frz});
		host.shift(8'hA5, 4, junk);
		host.close_frame();
		check8("freeze", 8'h00, {7'h00, frz});
		aux[1] = 1'b1;
		repeat (2) @(negedge clk);
		check8("address in reset", 8'h00, {1'b0, addr});
		aux[1] = 1'b0;
		repeat (4) @(negedge clk);
		single_read();
	endtask : restart
	task close_out;
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	// Main sequence
	initial
	begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'(i) ^ 8'hC3;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		single_read();
		multi_read();
		multi_write();
		read_write();
		restart();
		close_out();
	end
	// Watchdog
	initial
	begin
		#300000;
		miscompares++;
		close_out();
	end
endmodule : test_spi_register_bridge
